// ===== src/ealc_regs.vh
`ifndef EALC_REGS_VH
`define EALC_REGS_VH
// ----------------------------------------
// Register offsets (page-local address)
// ----------------------------------------
`define EALC_ADDR_ALARM_LATCH   5'h12
`define EALC_ADDR_FAS_COUNT     5'h13
`define EALC_ADDR_EBIT_HIGH     5'h14
`define EALC_ADDR_EBIT_LOW      5'h15
`define EALC_ADDR_BPV_HIGH      5'h16
`define EALC_ADDR_BPV_LOW       5'h17
`define EALC_ADDR_CRC4_HIGH     5'h18
`define EALC_ADDR_CRC4_LOW      5'h19
`define EALC_ADDR_IRQ_WORD0     5'h1b
`define EALC_ADDR_IRQ_MASK0     5'h1a
// ----------------------------------------
// Alarm latch bit positions
// ----------------------------------------
`define EALC_LAT_REMOTE         7
`define EALC_LAT_ALL_ONES       6
`define EALC_LAT_TS16           5
`define EALC_LAT_NO_SIGNAL      4
`define EALC_LAT_AUX            3
`define EALC_LAT_MULTIFRAME_ALARM_LATCH          2
`define EALC_LAT_SLIP           1
// ----------------------------------------
// Interrupt word zero bit positions
// ----------------------------------------
`define EALC_IRQ_TSYNC          7
`define EALC_IRQ_MFSYNC         6
`define EALC_IRQ_CRCSYNC        5
`define EALC_IRQ_ALL_ONES       4
`define EALC_IRQ_NO_SIGNAL      3
`define EALC_IRQ_TWO_FAS        2
`define EALC_IRQ_YBIT           1
`define EALC_IRQ_SLIP           0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define EALC_RST_BYTE           8'h00
`define EALC_RST_MASK           8'h00
`endif

// ===== src/ealc_top.v
// Functional notes
// - Latch bit 7 sets on received remote alarm; latch read clears it.
// - Latch bit 6 sets on all-ones alarm; held until latch read clears.
// - Latch bit 5 sets on timeslot 16 all ones; cleared by latch read.
// - Latch bit 4 sets on digital signal loss; cleared by latch read.
// - Latch bit 3 sets on auxiliary pattern; cleared by latch read.
// - Latch bit 2 sets on multiframe alarm; cleared by latch read.
// - Latch bit 1 sets on receive buffer slip; bit 0 unused, reads zero.
// - Eight-bit count of frame alignment words carrying bit errors.
// - Ten-bit E-bit count: top two bits in one register, low byte next.
// - Sixteen-bit bipolar violation count, high byte then low byte.
// - Ten-bit CRC-4 error count: top two bits, then low byte.
// - Interrupt bit 7 sets on terminal frame sync change, if unmasked.
// - Interrupt bit 6 sets on multiframe sync change, if unmasked.
// - Interrupt bit 5 sets on CRC-4 sync change, if unmasked.
// - Interrupt bit 4 sets when all-ones starts or ends, if unmasked.
// - Interrupt bit 3 sets while analog or digital signal loss exists.
// - Interrupt bit 2 sets on any alignment word error after the first one since reset.
// - Interrupt bit 1 sets on Y-bit multiframe loss status change.
// - Interrupt bit 0 sets on receive controlled slip, if unmasked.
// - Eight-bit error counts wrap to zero; wrap pulses an overflow output.
`timescale 1ns/1ps
`include "ealc_regs.vh"

module ealc_top
(
    input  wire       clk,
    input  wire       rst,
    // Microprocessor port, already in clk domain
    input  wire [4:0] addr,
    input  wire       rd_en,
    input  wire       wr_en,
    input  wire [7:0] wr_data,
    output reg  [7:0] rd_data_q,
    // Receive-side event pulses and levels
    input  wire       remote_alarm_evt,
    input  wire       all_ones_evt,
    input  wire       ts16_all_ones_evt,
    input  wire       digital_los_evt,
    input  wire       aux_pattern_evt,
    input  wire       mf_alarm_evt,
    input  wire       rx_slip_evt,
    input  wire       fas_error_evt,
    input  wire       ebit_error_evt,
    input  wire       bpv_evt,
    input  wire       crc4_error_evt,
    input  wire       term_sync_lvl,
    input  wire       mf_sync_lvl,
    input  wire       crc4_sync_lvl,
    input  wire       all_ones_lvl,
    input  wire       analog_los_lvl,
    input  wire       digital_los_lvl,
    input  wire       mf_loss_ybit_lvl,
    // Counter wrap pulses toward the overflow interrupt word
    output reg  [3:0] count_wrap_q
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    // Registered state
    reg [7:0]  alarm_latch_q;
    reg [7:0]  irq_word_q;
    reg [7:0]  irq_mask_q;
    reg [7:0]  fas_error_count_q;
    reg [9:0]  ebit_count_q;
    reg [15:0] bpv_count_q;
    reg [9:0]  crc4_count_q;
    reg [4:0]  lvl_prev_q;
    reg        fas_prev_err_q;
    // Next values of the registers above
    reg [7:0]  fas_error_count_d;
    reg [9:0]  ebit_count_d;
    reg [15:0] bpv_count_d;
    reg [9:0]  crc4_count_d;
    reg [3:0]  count_wrap_d;
    reg [7:0]  rd_data_d;

    // Combinational nets
    wire [7:0] latch_set;
    wire [7:0] alarm_latch_d;
    wire [7:0] irq_set;
    wire [7:0] irq_word_d;
    wire [4:0] lvl_now;
    wire [4:0] lvl_change;
    wire       latch_rd;
    wire       irq_rd;
    wire       mask_wr;
    genvar     gi;

    // ----------------------------------------
    // Register port decode
    // ----------------------------------------
    // Decode helper, shared by the clear-on-read and mask strobes
    function hit;
        input [4:0] a;
        input [4:0] target;
        input       strobe;
        begin
            hit = strobe && (a == target);
        end
    endfunction

    // Wrap test on a low byte, shared by all four counters
    function wraps;
        input       evt;
        input [7:0] low;
        begin
            wraps = evt && (low == 8'hff);
        end
    endfunction

    assign latch_rd = hit(addr, `EALC_ADDR_ALARM_LATCH, rd_en);
    assign irq_rd   = hit(addr, `EALC_ADDR_IRQ_WORD0, rd_en);
    // Only the mask is writable; writes anywhere else are dropped
    assign mask_wr  = hit(addr, `EALC_ADDR_IRQ_MASK0, wr_en);

    // ----------------------------------------
    // Alarm reporting latch
    // ----------------------------------------
    assign latch_set[`EALC_LAT_REMOTE]    = remote_alarm_evt;
    assign latch_set[`EALC_LAT_ALL_ONES]  = all_ones_evt;
    assign latch_set[`EALC_LAT_TS16]      = ts16_all_ones_evt;
    assign latch_set[`EALC_LAT_NO_SIGNAL] = digital_los_evt;
    assign latch_set[`EALC_LAT_AUX]       = aux_pattern_evt;
    assign latch_set[`EALC_LAT_MULTIFRAME_ALARM_LATCH]     = mf_alarm_evt;
    assign latch_set[`EALC_LAT_SLIP]      = rx_slip_evt;
    assign latch_set[0]                   = 1'b0;

    // One identical set/clear cell per latch bit; bit 0 has no source
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_latch_bit
            wire keep;
            // Set wins over read-clear so an event in the read cycle is kept
            assign keep              = alarm_latch_q[gi] & ~latch_rd;
            assign alarm_latch_d[gi] = latch_set[gi] | keep;
        end
    endgenerate

    // ----------------------------------------
    // Alarm latch register
    // ----------------------------------------
    // The read mux takes the old value at the same edge as the clear
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            alarm_latch_q <= `EALC_RST_BYTE;
        else
            alarm_latch_q <= alarm_latch_d;
    end

    // ----------------------------------------
    // Change detectors for interrupt word zero
    // ----------------------------------------
    // Levels come from receive logic on clk, so no synchroniser is needed
    assign lvl_now    = {term_sync_lvl, mf_sync_lvl, crc4_sync_lvl,
                         all_ones_lvl, mf_loss_ybit_lvl};
    assign lvl_change = lvl_now ^ lvl_prev_q;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lvl_prev_q     <= 5'h00;
            fas_prev_err_q <= 1'b0;
        end
        else
        begin
            lvl_prev_q <= lvl_now;
            if (fas_error_evt)
                fas_prev_err_q <= 1'b1;
        end
    end

    // Each alignment word arrives as a pulse only when errored, so a
    // second error pulse with the previous flag set marks two in a row.
    // Limitation: a clean word is never signalled, so the flag is never
    // cleared and any error after the first one sets the bit.
    assign irq_set[`EALC_IRQ_TSYNC]     = lvl_change[4];
    assign irq_set[`EALC_IRQ_MFSYNC]    = lvl_change[3];
    assign irq_set[`EALC_IRQ_CRCSYNC]   = lvl_change[2];
    assign irq_set[`EALC_IRQ_ALL_ONES]  = lvl_change[1];
    assign irq_set[`EALC_IRQ_NO_SIGNAL] = analog_los_lvl | digital_los_lvl;
    assign irq_set[`EALC_IRQ_TWO_FAS]   = fas_error_evt & fas_prev_err_q;
    assign irq_set[`EALC_IRQ_YBIT]      = lvl_change[0];
    assign irq_set[`EALC_IRQ_SLIP]      = rx_slip_evt;

    // ----------------------------------------
    // Interrupt word zero and its mask
    // ----------------------------------------
    // Per-bit cell: the mask gates the set, the read clears the rest
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_irq_bit
            wire set_en;
            wire keep;
            // Masked events leave the bit alone; an unmasked set beats the clear
            assign set_en         = irq_set[gi] & irq_mask_q[gi];
            assign keep           = irq_word_q[gi] & ~irq_rd;
            assign irq_word_d[gi] = set_en | keep;
        end
    endgenerate

    // Mask writes act on events from the next edge on
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_word_q <= `EALC_RST_BYTE;
            irq_mask_q <= `EALC_RST_MASK;
        end
        else
        begin
            if (mask_wr)
                irq_mask_q <= wr_data;
            irq_word_q <= irq_word_d;
        end
    end

    // ----------------------------------------
    // Performance counters
    // ----------------------------------------
    // All counters wrap; the 8-bit one and the low bytes report wraps
    always @*
    begin
        fas_error_count_d = fas_error_count_q;
        ebit_count_d      = ebit_count_q;
        bpv_count_d       = bpv_count_q;
        crc4_count_d      = crc4_count_q;
        if (fas_error_evt)
            fas_error_count_d = fas_error_count_q + 8'h01;
        if (ebit_error_evt)
            ebit_count_d = ebit_count_q + 10'h001;
        if (bpv_evt)
            bpv_count_d = bpv_count_q + 16'h0001;
        if (crc4_error_evt)
            crc4_count_d = crc4_count_q + 10'h001;
        // Wrap pulses: FAS, CRC-4, E-bit, BPV on a low byte of FFH
        count_wrap_d = {wraps(fas_error_evt, fas_error_count_q),
                        wraps(crc4_error_evt, crc4_count_q[7:0]),
                        wraps(ebit_error_evt, ebit_count_q[7:0]),
                        wraps(bpv_evt, bpv_count_q[7:0])};
    end

    // ----------------------------------------
    // Counter registers
    // ----------------------------------------
    // Counters are not snapshotted, so a high byte read and a later low
    // byte read can tear across a carry; software reads twice if needed
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            fas_error_count_q <= `EALC_RST_BYTE;
            ebit_count_q      <= 10'h000;
            bpv_count_q       <= 16'h0000;
            crc4_count_q      <= 10'h000;
            count_wrap_q      <= 4'h0;
        end
        else
        begin
            fas_error_count_q <= fas_error_count_d;
            ebit_count_q      <= ebit_count_d;
            bpv_count_q       <= bpv_count_d;
            crc4_count_q      <= crc4_count_d;
            count_wrap_q      <= count_wrap_d;
        end
    end

    // ----------------------------------------
    // Read data mux
    // ----------------------------------------
    // Address decode for reads; the mask reads back as stored and
    // unmapped places return zero
    always @*
    begin
        rd_data_d = `EALC_RST_BYTE;
        case (addr)
            `EALC_ADDR_ALARM_LATCH: rd_data_d = alarm_latch_q;
            `EALC_ADDR_FAS_COUNT:   rd_data_d = fas_error_count_q;
            `EALC_ADDR_EBIT_HIGH:   rd_data_d = {6'h00, ebit_count_q[9:8]};
            `EALC_ADDR_EBIT_LOW:    rd_data_d = ebit_count_q[7:0];
            `EALC_ADDR_BPV_HIGH:    rd_data_d = bpv_count_q[15:8];
            `EALC_ADDR_BPV_LOW:     rd_data_d = bpv_count_q[7:0];
            `EALC_ADDR_CRC4_HIGH:   rd_data_d = {6'h00, crc4_count_q[9:8]};
            `EALC_ADDR_CRC4_LOW:    rd_data_d = crc4_count_q[7:0];
            `EALC_ADDR_IRQ_MASK0:   rd_data_d = irq_mask_q;
            `EALC_ADDR_IRQ_WORD0:   rd_data_d = irq_word_q;
            default:                rd_data_d = `EALC_RST_BYTE;
        endcase
    end

    // ----------------------------------------
    // Read data register
    // ----------------------------------------
    // Data appears one edge after rd_en and holds until the next read
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            rd_data_q <= `EALC_RST_BYTE;
        else if (rd_en)
            rd_data_q <= rd_data_d;
    end

endmodule

// ===== testbench/ealc_host.sv
`timescale 1ns/1ps
// Host side of the register port; strobes change only after a falling edge
module ealc_host
(
    input  wire  logic       clk,
    output logic       [4:0] addr,
    output logic             rd_en,
    output logic             wr_en,
    output logic       [7:0] wr_data
);
    // Idle bus at time zero
    initial
    begin
        addr = 5'h00;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wr_data = 8'h00;
    end
    // One-cycle read strobe; address inverted after release so stale values never match
    task rd(input [4:0] a);
        @(negedge clk);
        addr = a;
        rd_en = 1'b1;
        @(negedge clk);
        rd_en = 1'b0;
        addr = ~a;
    endtask
    // One-cycle write strobe, data inverted after release
    task wr(input [4:0] a, input [7:0] d);
        @(negedge clk);
        addr = a;
        wr_data = d;
        wr_en = 1'b1;
        @(negedge clk);
        wr_en = 1'b0;
        wr_data = ~d;
    endtask
endmodule

// ===== testbench/ealc_top_sva.sv
`timescale 1ns/1ps
module ealc_top_sva
(
    input logic       clk,
    input logic       rst,
    input logic [4:0] addr,
    input logic       rd_en,
    input logic       wr_en,
    input logic [7:0] wr_data,
    input logic [7:0] rd_data_q,
    input logic       remote_alarm_evt,
    input logic       rx_slip_evt,
    input logic       term_sync_lvl,
    input logic [3:0] count_wrap_q
);
    logic [7:0] mask_q;
    logic       lr;
    logic       ir;
    // Shadow of the enable register, so interrupt checks know which bits may set
    always @(posedge clk or posedge rst)
        if (rst)
            mask_q <= 8'h00;
        else if (wr_en && addr == 5'h1a)
            mask_q <= wr_data;
    // Reads of the latch and of the interrupt word
    assign lr = rd_en && addr == 5'h12;
    assign ir = rd_en && addr == 5'h1b;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Cause, a cycle with no read that could clear it, then the reporting read
    sequence late_rd(e, r);
        e ##1 !r ##1 r;
    endsequence
    a_lat_remote: assert property (late_rd(remote_alarm_evt, lr) |=> rd_data_q[7])
        else $error("remote alarm latch bit missing");
    a_lat_slip: assert property (late_rd(rx_slip_evt, lr) |=> rd_data_q[1])
        else $error("slip latch bit missing");
    a_lat_clear: assert property
        (lr && !remote_alarm_evt ##1 !remote_alarm_evt ##1 lr |=> !rd_data_q[7])
        else $error("latch bit survived its read");
    a_lat_unused: assert property (lr |=> !rd_data_q[0])
        else $error("unused latch bit set");
    a_high_unused: assert property
        (rd_en && (addr == 5'h14 || addr == 5'h18) |=> rd_data_q[7:2] == 6'h00)
        else $error("unused high count bits set");
    a_mask_back: assert property
        (wr_en && addr == 5'h1a ##1 !(wr_en && addr == 5'h1a) ##1 rd_en && addr == 5'h1a
         |=> rd_data_q == $past(wr_data, 3))
        else $error("enable register readback wrong");
    a_irq_tsync: assert property
        (late_rd($changed(term_sync_lvl) && mask_q[7], ir) |=> rd_data_q[7])
        else $error("sync change interrupt missing");
    a_irq_slip: assert property (late_rd(rx_slip_evt && mask_q[0], ir) |=> rd_data_q[0])
        else $error("slip interrupt missing");
    a_irq_masked: assert property
        (ir && mask_q == 8'h00 ##1 mask_q == 8'h00 ##1 ir |=> rd_data_q == 8'h00)
        else $error("masked interrupt bit set");
    a_wrap_pulse: assert property ((count_wrap_q & $past(count_wrap_q)) == 4'h0)
        else $error("wrap pulse longer than a cycle");
endmodule
bind ealc_top ealc_top_sva u_sva (.*);

// ===== testbench/e1_alarm_latch_error_counters_test.sv
`timescale 1ns/1ps
module e1_alarm_latch_error_counters_test;
    logic        clk;
    logic        rst = 1'b1;
    logic        rd_en, wr_en;
    logic [4:0]  addr;
    logic [7:0]  wr_data, rd_data_q, n, m;
    logic [3:0]  count_wrap_q;
    logic [3:0]  wv = 4'h0;
    logic [18:0] ev = 19'h0;
    logic [7:0]  q[$];
    integer      seed = 32'h01df6a70;
    integer      miscompares = 0, checks_done = 0, wk = 0, i, r;
    ealc_host H (.clk(clk), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data));
    // ev: [6:0] latch bits 7..1, [10:7] fas/crc4/ebit/bpv, [18:11] interrupt bits 7..0
    ealc_top DUT
    (
        .clk(clk), .rst(rst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
        .rd_data_q(rd_data_q), .count_wrap_q(count_wrap_q), .remote_alarm_evt(ev[6]),
        .all_ones_evt(ev[5]), .ts16_all_ones_evt(ev[4]), .digital_los_evt(ev[3]),
        .aux_pattern_evt(ev[2]), .mf_alarm_evt(ev[1]), .rx_slip_evt(ev[0] | ev[11]),
        .fas_error_evt(ev[10] | ev[13]), .crc4_error_evt(ev[9]), .ebit_error_evt(ev[8]),
        .bpv_evt(ev[7]), .term_sync_lvl(ev[18]), .mf_sync_lvl(ev[17]), .crc4_sync_lvl(ev[16]),
        .all_ones_lvl(ev[15]), .analog_los_lvl(ev[14]), .digital_los_lvl(ev[3]),
        .mf_loss_ybit_lvl(ev[12])
    );
    // 20 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    task chk(input [7:0] got, input [7:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
        end
    endtask
    // Note the expectation, then read through the host
    task rx(input [4:0] a, input [7:0] e);
        q.push_back(e);
        H.rd(a);
    endtask
    // Sources high for exactly one clock
    task pulse(input [18:0] v);
        @(negedge clk);
        ev = v;
        @(negedge clk);
        ev = 19'h0;
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Read data lands one cycle after its strobe; oldest note is matched
    always @(posedge clk)
        if (rd_en === 1'b1)
        begin
            @(negedge clk);
            chk(rd_data_q, q.pop_front());
        end
    // Wrap pulses: how many cycles, and which counters
    always @(negedge clk)
        wk += (count_wrap_q != 4'h0);
    always @(negedge clk)
        wv |= count_wrap_q;
    initial
    begin
        #200000;
        miscompares++;
        test_done;
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        // Upper half of the page (16 to 31) after reset, unmapped places included, reads zero
        for (i = 16; i < 32; i++)
            rx(i[4:0], 8'h00);
        // A write to a counter is refused
        H.wr(5'h13, 8'hff);
        rx(5'h13, 8'h00);
        for (i = 0; i < 7; i++)
        begin
            pulse(19'h1 << i);
            rx(5'h12, 8'h02 << i);
            rx(5'h12, 8'h00);
        end
        repeat (4)
        begin
            r = $random(seed);
            m = r[7:0];
            pulse({12'h0, m[6:0]});
            rx(5'h12, {m[6:0], 1'b0});
        end
        // Short run of errors, then 256 more so every low byte wraps once
        n = {4'h0, m[3:0]} + 8'h01;
        for (int p = 0; p < 2; p++)
        begin
            repeat (p ? 256 : n) pulse(19'h780);
            for (i = 19; i < 26; i++)
                rx(i[4:0], i[0] ? n : {7'h0, p[0]});
        end
        chk({wk[3:0], wv}, 8'h1f);
        // Enables off, on, then random; one source per interrupt bit fires once
        for (i = 0; i < 4; i++)
        begin
            r = $random(seed);
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : r[7:0];
            H.wr(5'h1a, m);
            rx(5'h1a, m);
            // Odd runs swap the analog loss level for the digital one
            pulse(i[0] ? 19'h7b808 : 19'h7f800);
            rx(5'h1b, m);
            rx(5'h1b, 8'h00);
        end
        test_done;
    end
endmodule
